/* verilog/uscb_top.sv */
// serial port flags, control and bit-rate divisor behind an ahb-lite slave
//
// The AHB-Lite interface to the registers was decided locally.
`include "uscb_consts.svh"
module uscb_top (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	// ahb-lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	// receive engine
	input wire logic [7:0] i_rx_data,
	input wire logic i_rx_byte_done,
	input wire logic i_rx_parity_err,
	input wire logic i_rx_overrun,
	input wire logic i_rx_frame_err,
	input wire logic i_rx_break,
	input wire logic i_rx_noise,
	output logic o_rx_data_rd,
	// transmit engine
	input wire logic i_tx_busy,
	input wire logic i_tx_load,
	input wire logic i_tx_serial,
	output logic o_tx_data_wr,
	output logic [7:0] o_tx_data,
	output logic o_txd,
	// stop-mode recovery
	input wire logic i_stop_recover,
	// configuration to the engines
	output logic o_tx_en,
	output logic o_rx_en,
	output logic o_irq_en,
	output logic o_par_en,
	output logic o_par_odd,
	output logic o_two_stop,
	output logic o_noise_filter_en,
	// bit-rate generator
	output logic o_bit_tick,
	output logic o_timer_irq
);
	uscb_pkg::uscb_phase_type phase_r;
	logic [7:0] widx_r;
	logic [7:0] ctrl_r;
	logic [7:0] div_r;
	logic [7:0] cnt_r;
	logic [3:0] pre_r;
	logic filt_r;
	logic thr_full_r;
	logic tx_done_r;
	logic [5:0] sticky_r;
	logic [31:0] hrdata_r;
	logic tx_wr_r;
	logic [7:0] tx_data_r;
	logic txd_r;
	logic bit_tick_r;
	logic timer_irq_r;
	logic [7:0] tick_gap_r;

	// address phase decode
	wire acc = i_hsel & i_hready & i_htrans[1];
	wire hi_ok = (i_haddr[31:10] == 22'h0);
	wire [7:0] idx = i_haddr[9:2];
	wire rd_acc = acc & ~i_hwrite;
	wire rd_data = rd_acc & hi_ok & (idx == `USCB_IDX_DATA);
	wire rd_flags = rd_acc & hi_ok & (idx == `USCB_IDX_FLAGS);
	wire rd_ctrl = rd_acc & hi_ok & (idx == `USCB_IDX_CTRL);
	wire rd_div = rd_acc & hi_ok & (idx == `USCB_IDX_DIV);

	// data phase write decode
	wire wr_en = (phase_r == uscb_pkg::USCB_WR);
	wire wr_data = wr_en & (widx_r == `USCB_IDX_DATA);
	wire wr_flags = wr_en & (widx_r == `USCB_IDX_FLAGS);
	wire wr_ctrl = wr_en & (widx_r == `USCB_IDX_CTRL);
	wire wr_div = wr_en & (widx_r == `USCB_IDX_DIV);

	wire timer_mode = ctrl_r[`USCB_CT_TIMER];
	wire thr_ready = ctrl_r[`USCB_CT_TXEN] & ~thr_full_r;
	wire [7:0] flags = {sticky_r[5:1], thr_ready, tx_done_r, sticky_r[0]};
	// live count only in timer mode
	wire [7:0] div_view = timer_mode ? cnt_r : div_r;

	// sticky receive events, bit order rxf par ovr frm brk noise
	wire [5:0] ev = {i_rx_byte_done, i_rx_parity_err, i_rx_overrun,
		i_rx_frame_err, i_rx_break, i_rx_noise};
	wire flag_clr = rd_data | i_stop_recover;

	// bit-rate generator: /16 prescale then 8-bit down counter
	wire pre_tick = (pre_r == `USCB_PRESCALE_LAST);
	wire reload = pre_tick & (cnt_r == `USCB_CNT_RELOAD_AT) & ~wr_div;

	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign o_hrdata = hrdata_r;
	assign o_rx_data_rd = rd_data;
	assign o_tx_data_wr = tx_wr_r;
	assign o_tx_data = tx_data_r;
	assign o_txd = txd_r;
	assign o_tx_en = ctrl_r[`USCB_CT_TXEN];
	assign o_rx_en = ctrl_r[`USCB_CT_RXEN];
	assign o_irq_en = ctrl_r[`USCB_CT_IE];
	assign o_par_en = ctrl_r[`USCB_CT_PAREN];
	assign o_par_odd = ctrl_r[`USCB_CT_ODD];
	assign o_two_stop = ctrl_r[`USCB_CT_STOP2];
	assign o_noise_filter_en = filt_r;
	assign o_bit_tick = bit_tick_r;
	assign o_timer_irq = timer_irq_r;

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			phase_r <= uscb_pkg::USCB_IDLE;
			widx_r <= 8'h00;
		end else if (acc & i_hwrite & hi_ok) begin
			phase_r <= uscb_pkg::USCB_WR;
			widx_r <= idx;
		end else if (acc) begin
			phase_r <= uscb_pkg::USCB_RD;
			widx_r <= 8'h00;
		end else begin
			phase_r <= uscb_pkg::USCB_IDLE;
			widx_r <= 8'h00;
		end
	end

	// read data sampled at the address phase; unmapped reads give zero
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn)
			hrdata_r <= 32'h0;
		else if (rd_acc)
			hrdata_r <= {24'h0,
				({8{rd_data}} & i_rx_data) | ({8{rd_flags}} & flags) |
				({8{rd_ctrl}} & ctrl_r) | ({8{rd_div}} & div_view)};
	end

	// stop-mode recovery deliberately absent here
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ctrl_r <= `USCB_CTRL_RST;
			div_r <= `USCB_DIV_RST;
			filt_r <= 1'b0;
		end else begin
			if (wr_ctrl)
				ctrl_r <= i_hwdata[7:0];
			if (wr_div)
				div_r <= i_hwdata[7:0];
			if (wr_flags)
				filt_r <= i_hwdata[`USCB_ST_NOISE];
		end
	end

	// set wins over the read clear
	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1) begin : g_sticky
			always_ff @(posedge i_ref_clk or negedge i_resetn) begin
				if (!i_resetn)
					sticky_r[g] <= 1'b0;
				else
					sticky_r[g] <= ev[g] | (sticky_r[g] & ~flag_clr);
			end
		end
	endgenerate

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			thr_full_r <= 1'b0;
			tx_done_r <= 1'b1;
			tx_wr_r <= 1'b0;
			tx_data_r <= 8'h00;
			txd_r <= 1'b1;
		end else begin
			thr_full_r <= wr_data | (thr_full_r & ~i_tx_load);
			tx_done_r <= ~i_tx_busy & ~thr_full_r;
			tx_wr_r <= wr_data;
			if (wr_data)
				tx_data_r <= i_hwdata[7:0];
			txd_r <= i_tx_serial & ~ctrl_r[`USCB_CT_BRK];
		end
	end

	// zero counts as 256 steps: 0 wraps to ff, giving clock/4096
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pre_r <= 4'h0;
			cnt_r <= `USCB_DIV_RST;
			bit_tick_r <= 1'b0;
			timer_irq_r <= 1'b0;
		end else begin
			pre_r <= pre_r + 4'h1;
			if (wr_div)
				cnt_r <= i_hwdata[7:0];
			else if (reload)
				cnt_r <= div_r;
			else if (pre_tick)
				cnt_r <= cnt_r - 8'h01;
			bit_tick_r <= reload & ~timer_mode;
			timer_irq_r <= reload & timer_mode & ctrl_r[`USCB_CT_IE];
		end
	end

	// cycles since the last bit tick, saturating; checking aid only
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn)
			tick_gap_r <= 8'hff;
		else if (o_bit_tick)
			tick_gap_r <= 8'h00;
		else if (tick_gap_r != 8'hff)
			tick_gap_r <= tick_gap_r + 8'h01;
	end

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);

	a_rx_full_set: assert property (i_rx_byte_done |=> flags[7])
		else $error("receive-full not set");
	a_rx_full_clear: assert property (
		rd_data && !i_rx_byte_done |=> !flags[7])
		else $error("receive-full not cleared by read");
	a_err_clear: assert property (
		rd_data && !(|ev[4:1]) |=> flags[6:3] == 4'h0)
		else $error("error flags not cleared by read");
	a_parity_set: assert property (i_rx_parity_err |=> flags[6])
		else $error("parity flag not set");
	a_overrun_set: assert property (i_rx_overrun |=> flags[5])
		else $error("overrun flag not set");
	a_framing_set: assert property (i_rx_frame_err |=> flags[4])
		else $error("framing flag not set");
	a_break_set: assert property (i_rx_break |=> flags[3])
		else $error("break flag not set");
	a_thr_busy: assert property (wr_data && !i_tx_load |=> !flags[2])
		else $error("holding-ready stays up after write");
	a_tx_busy: assert property (i_tx_busy |=> !flags[1])
		else $error("transmit-complete high while shifting");
	a_filter_write: assert property (
		wr_flags |=> filt_r == $past(i_hwdata[0]))
		else $error("noise filter enable not written");
	a_break_out: assert property (
		ctrl_r[2] && $past(ctrl_r[2]) |-> !o_txd)
		else $error("serial output not held low in break");
	a_timer_irq: assert property (
		reload && timer_mode && ctrl_r[5] |=> o_timer_irq ##1 !o_timer_irq)
		else $error("timer reload did not raise one request");
	// ticks only leave on prescaler wraps, so spacing is a multiple of 16
	a_bit_rate: assert property (
		o_bit_tick |-> tick_gap_r[3:0] == 4'hf)
		else $error("bit tick spacing wrong");
	a_ctrl_kept: assert property (
		i_stop_recover && !wr_ctrl && !wr_div |=>
		$stable(ctrl_r) && $stable(div_r))
		else $error("control lost on stop recovery");

	// engine hand-off, divisor view and timer reload
	a_tx_strobe: assert property (
		wr_data |=> o_tx_data_wr && o_tx_data == $past(i_hwdata[7:0]))
		else $error("holding byte not passed on");
	a_noise_set: assert property (i_rx_noise |=> flags[0])
		else $error("noise flag not set");
	a_tick_quiet: assert property (timer_mode |=> !o_bit_tick)
		else $error("bit tick in timer mode");
	a_div_view: assert property (
		rd_div && timer_mode |=> o_hrdata[7:0] == $past(cnt_r))
		else $error("live count not returned");
	a_reload_value: assert property (
		reload |=> cnt_r == $past(div_r))
		else $error("counter reload value wrong");
	a_irq_quiet: assert property (
		!(timer_mode && ctrl_r[5]) |=> !o_timer_irq)
		else $error("timer request outside timer mode");

	c_rx_read: cover property (i_rx_byte_done ##[1:20] rd_data);
	c_timer_irq: cover property (o_timer_irq);
	c_break_send: cover property (ctrl_r[2] ##1 !o_txd);
	c_ctrl_write: cover property (wr_ctrl ##1 o_tx_en);
	c_bit_tick: cover property (o_bit_tick);
endmodule : uscb_top

/* verilog/uscb_consts.svh */
// register indices, field positions and reset values of the serial port
`ifndef USCB_CONSTS_SVH
`define USCB_CONSTS_SVH
`define USCB_IDX_DATA 8'hf1
`define USCB_IDX_FLAGS 8'hf2
`define USCB_IDX_CTRL 8'hf3
`define USCB_IDX_DIV 8'hf4
`define USCB_FLAGS_RST 8'h02
`define USCB_CTRL_RST 8'h00
`define USCB_DIV_RST 8'hff
`define USCB_ST_RXF 7
`define USCB_ST_PAR 6
`define USCB_ST_OVR 5
`define USCB_ST_FRM 4
`define USCB_ST_BRK 3
`define USCB_ST_THR 2
`define USCB_ST_TXC 1
`define USCB_ST_NOISE 0
`define USCB_CT_TXEN 7
`define USCB_CT_RXEN 6
`define USCB_CT_IE 5
`define USCB_CT_PAREN 4
`define USCB_CT_ODD 3
`define USCB_CT_BRK 2
`define USCB_CT_STOP2 1
`define USCB_CT_TIMER 0
`define USCB_PRESCALE_LAST 4'hf
`define USCB_CNT_RELOAD_AT 8'h01
`endif

/* verilog/uscb_pkg.sv */
// types shared by the serial port status, control and divisor logic
package uscb_pkg;
	typedef enum logic [1:0] {
		USCB_IDLE,
		USCB_RD,
		USCB_WR
	} uscb_phase_type;
endpackage : uscb_pkg

/* bench/uscb_engine_model.sv */
// far-side engine model: receive event source and transmit shifter
module uscb_engine_model (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	// bench commands and design strobes
	input wire logic [5:0] i_ev_cmd,
	input wire logic i_tx_data_wr,
	// engine outputs to the design
	output logic [5:0] o_ev,
	output logic o_tx_busy,
	output logic o_tx_load,
	output logic o_tx_serial
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] cnt_r;
	// slow take of the byte keeps the holding flag low for a while
	assign o_tx_load = (cnt_r == 5'h4);
	assign o_tx_busy = (cnt_r > 5'h4);
	assign o_tx_serial = o_tx_busy ? cnt_r[1] : 1'b1;
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt_r <= 5'h0;
			o_ev <= 6'h0;
		end else begin
			o_ev <= i_ev_cmd;
			if (i_tx_data_wr)
				cnt_r <= 5'h1;
			else if (cnt_r != 5'h0)
				cnt_r <= cnt_r + 5'h1;
		end
	end
endmodule : uscb_engine_model

/* bench/testbench.sv */
// self-checking bench for the serial port register block
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_ref_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic stop_rec = 1'b0;
	logic [5:0] ev_cmd = 6'h0;
	logic [31:0] hrdata, rd;
	logic [5:0] ev;
	logic [7:0] tx_data;
	logic hready, tx_busy, tx_load, tx_ser, tx_wr, txd, tx_en, rx_en;
	logic irq_en, par_en, par_odd, two_stop, nf_en, bit_tick, timer_irq;
	logic rx_rd, hresp;
	int rx_rds = 0;
	int mismatches = 0;
	int n_tests = 0;
	int cycles = 0;
	int c;
	initial forever #25 i_ref_clk = ~i_ref_clk;
	task automatic results();
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results
	always @(posedge i_ref_clk) begin
		cycles++;
		if (rx_rd === 1'b1)
			rx_rds++;
		if (cycles == 20000) begin
			mismatches++;
			results();
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : check
	task automatic bus(input logic w, input logic [7:0] idx,
		input logic [7:0] d);
		@(posedge i_ref_clk);
		haddr <= {22'h0, idx, 2'b00};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge i_ref_clk);
		while (!hready) @(posedge i_ref_clk);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		@(posedge i_ref_clk);
		while (!hready) @(posedge i_ref_clk);
		rd = hrdata;
	endtask : bus
	task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00);
		check(rd, {24'h0, exp});
	endtask : rdchk
	task automatic pulses(input bit tmr, input int n, output int k);
		k = 0;
		repeat (n) begin
			@(posedge i_ref_clk);
			k += tmr ? int'(timer_irq) : int'(bit_tick);
		end
	endtask : pulses
	uscb_top i_uscb_top (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
		.i_hsel(1'b1), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
		.o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
		.i_rx_data(8'ha5), .i_rx_byte_done(ev[5]), .i_rx_parity_err(ev[4]),
		.i_rx_overrun(ev[3]), .i_rx_frame_err(ev[2]), .i_rx_break(ev[1]),
		.i_rx_noise(ev[0]), .o_rx_data_rd(rx_rd), .i_tx_busy(tx_busy),
		.i_tx_load(tx_load), .i_tx_serial(tx_ser), .o_tx_data_wr(tx_wr),
		.o_tx_data(tx_data), .o_txd(txd), .i_stop_recover(stop_rec),
		.o_tx_en(tx_en), .o_rx_en(rx_en), .o_irq_en(irq_en),
		.o_par_en(par_en), .o_par_odd(par_odd), .o_two_stop(two_stop),
		.o_noise_filter_en(nf_en), .o_bit_tick(bit_tick),
		.o_timer_irq(timer_irq));
	uscb_engine_model i_uscb_engine_model (.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn), .i_ev_cmd(ev_cmd), .i_tx_data_wr(tx_wr),
		.o_ev(ev), .o_tx_busy(tx_busy), .o_tx_load(tx_load),
		.o_tx_serial(tx_ser));
	initial begin
		repeat (6) @(posedge i_ref_clk);
		i_resetn <= 1'b1;
		rdchk(8'hf2, 8'h02);
		rdchk(8'hf3, 8'h00);
		rdchk(8'hf4, 8'hff);
		$display("test reset done");
		bus(1'b1, 8'hf3, 8'hc0);
		@(negedge i_ref_clk) check({tx_en, rx_en}, 2'b11);
		rdchk(8'hf2, 8'h06);
		@(posedge i_ref_clk) ev_cmd <= 6'h3f;
		@(posedge i_ref_clk) ev_cmd <= 6'h00;
		repeat (3) @(posedge i_ref_clk);
		rdchk(8'hf2, 8'hff);
		rdchk(8'hf1, 8'ha5);
		check(rx_rds, 1);
		rdchk(8'hf2, 8'h06);
		@(negedge i_ref_clk) check({hresp, rx_rd}, 2'b00);
		$display("test receive done");
		bus(1'b1, 8'hf1, 8'h5a);
		rdchk(8'hf2, 8'h00);
		check(tx_data, 8'h5a);
		repeat (40) @(posedge i_ref_clk);
		rdchk(8'hf2, 8'h06);
		bus(1'b1, 8'hf3, 8'hc4);
		repeat (2) @(posedge i_ref_clk);
		check(txd, 1'b0);
		bus(1'b1, 8'hf3, 8'hc0);
		repeat (3) @(posedge i_ref_clk);
		check(txd, 1'b1);
		$display("test transmit done");
		bus(1'b1, 8'hf2, 8'hff);
		@(negedge i_ref_clk) check(nf_en, 1'b1);
		rdchk(8'hf2, 8'h06);
		bus(1'b1, 8'hf2, 8'h00);
		@(negedge i_ref_clk) check(nf_en, 1'b0);
		rdchk(8'h20, 8'h00);
		$display("test flags done");
		bus(1'b1, 8'hf3, 8'h00);
		bus(1'b1, 8'hf4, 8'h02);
		pulses(1'b0, 168, c);
		check(c, 5);
		bus(1'b1, 8'hf4, 8'h00);
		pulses(1'b0, 8200, c);
		check(c, 2);
		bus(1'b1, 8'hf4, 8'h03);
		bus(1'b1, 8'hf3, 8'h3b);
		@(negedge i_ref_clk) check({irq_en, par_en, par_odd, two_stop}, 4'hf);
		bus(1'b0, 8'hf4, 8'h00);
		check(rd[7:0] inside {8'h01, 8'h02, 8'h03}, 1'b1);
		pulses(1'b1, 192, c);
		check(c, 4);
		@(posedge i_ref_clk) stop_rec <= 1'b1;
		@(posedge i_ref_clk) stop_rec <= 1'b0;
		rdchk(8'hf3, 8'h3b);
		bus(1'b1, 8'hf3, 8'h00);
		rdchk(8'hf4, 8'h03);
		$display("test divisor done");
		results();
	end
endmodule : testbench
